// >>> rtl/bbsr_defines.svh
// Offsets, field positions, reset values and key for the backup reference regs.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef BBSR_DEFINES_SVH
`define BBSR_DEFINES_SVH

// ==========================================
// Register byte offsets
`define BBSR_UNLOCK_OFF 12'h018
`define BBSR_REFCTRL_OFF 12'h05C
`define BBSR_REFSTAT_OFF 12'h060
`define BBSR_BR_BASE_OFF 12'h078
`define BBSR_BR_COUNT 4
`define BBSR_BRIF_VER_OFF 12'h3E4
`define BBSR_REFIF_VER_OFF 12'h3E8
`define BBSR_REGIF_VER_OFF 12'h3EC
`define BBSR_BODIF_VER_OFF 12'h3F0

// ==========================================
// Field positions
`define BBSR_SEL_LSB 0
`define BBSR_BUFRDY_LSB 0
`define BBSR_MAINRDY_BIT 16
`define BBSR_LPRDY_BIT 17
`define BBSR_VREF_LSB 18
`define BBSR_KEY_LSB 24
`define BBSR_UNLOCK_ADDR_W 10

// ==========================================
// Values
`define BBSR_SEL_NONE 2'h0
`define BBSR_SEL_VREF 2'h2
`define BBSR_UNLOCK_KEY 8'hAA
`define BBSR_WORD_RESET 32'h0000_0000
`define BBSR_BRIF_VER 32'h0000_0100
`define BBSR_REFIF_VER 32'h0000_0110
`define BBSR_REGIF_VER 32'h0000_0110
`define BBSR_BODIF_VER 32'h0000_0110

`endif

// >>> rtl/bbsr_pkg.sv
// Types shared by the backup reference register block.
// Assumes bbsr_defines.svh is compiled alongside.
package bbsr_pkg;

   // ==========================================
   // Register state
   typedef struct packed {
      logic [1:0] adc_ref_input_select;
      logic unlocked;
      logic [9:0] unlock_addr;
      logic [3:0][31:0] retained_general_word;
      logic [31:0] rdata;
      logic slverr;
   } bbsr_state_s;

   typedef logic [11:0] bbsr_addr_t;

endpackage

// >>> rtl/bbsr_sync.sv
// Two-flop synchroniser for the analog reference status levels.
// Assumes inputs are slow quasi-static levels from the analog domain.
`timescale 1ns/1ps
`default_nettype none

module bbsr_sync #(
   parameter int WIDTH = 12
) (
   input wire logic core_clk_i, // Core clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic [WIDTH-1:0] async_i, // Levels from outside
   output logic [WIDTH-1:0] sync_o // Synchronised levels
);

   // Both stages in one record
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } bbsr_sync_s;

   bbsr_sync_s st_q;
   bbsr_sync_s st_d;

   // ==========================================
   // First stage feeds only the second
   always_comb begin
      st_d.meta = async_i;
      st_d.sync = st_q.meta;
   end

   // Reset to not-ready so nothing reads ready before the levels settle
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_o = st_q.sync;

endmodule

`default_nettype wire

// >>> rtl/bbsr_regs.sv
// Backup-domain reference status and retained register bank, APB slave.
// Assumes analog status arrives asynchronously and rst_n_i is the backup reset.
//
// Notes on behaviour
// [R1] ADC select: 0 leaves ADC unconnected, 2 routes reference; 1 and 3 reserved.
// [R2] Usage field: 0 both, 1 main only, 2 low-power only, 3 none.
// [R3] Bit 17 reads one only once the low-power reference is ready.
// [R4] Bit 16 reads one only once the main reference is ready.
// [R5] Eight buffer-ready bits, one per reference buffer.
// [R6] Retained words are 32-bit read/write, reset to zero, kept in backup mode.
// [R7] Retained word writes need an unlock write just before; others are rejected.
// [R8] Version registers are read-only, twelve-bit version in the low bits.
// [R9] Writes to status and version registers change nothing.
//
// The APB register port was left to the implementer.
`include "bbsr_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module bbsr_regs (
   input wire logic core_clk_i, // 100 MHz clock
   input wire logic rst_n_i, // Async reset, active low
   input wire logic psel_i, // APB select
   input wire logic penable_i, // APB enable
   input wire logic pwrite_i, // APB direction
   input wire logic [11:0] paddr_i, // APB byte address
   input wire logic [31:0] pwdata_i, // APB write data
   input wire logic [3:0] pstrb_i, // APB byte strobes
   output logic [31:0] prdata_o, // APB read data
   output logic pready_o, // APB ready
   output logic pslverr_o, // APB error
   input wire logic [1:0] vref_used_i, // Reference usage code, async
   input wire logic main_ref_ready_i, // Main reference ready, async
   input wire logic lowpower_ref_ready_i, // Low-power reference ready, async
   input wire logic [7:0] ref_buffer_ready_i, // Buffer ready bits, async
   output logic [1:0] adc_ref_input_select_o, // Selector field
   output logic adc_ref_connect_o // Reference routed to ADC
);

   // ==========================================
   // Helpers
   function automatic logic hit(input bbsr_pkg::bbsr_addr_t a, input bbsr_pkg::bbsr_addr_t off);
      hit = (a[11:2] == off[11:2]);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      merge = r;
   endfunction

   // ==========================================
   // Status synchronisation
   logic [11:0] stat_s;
   bbsr_sync #(.WIDTH(12)) u_sync (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .async_i({vref_used_i, lowpower_ref_ready_i, main_ref_ready_i, ref_buffer_ready_i}),
      .sync_o(stat_s)
   );

   logic [31:0] status_word;
   // Status word assembled from synced levels only
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`BBSR_VREF_LSB +: 2] = stat_s[11:10]; // R2
      status_word[`BBSR_LPRDY_BIT] = stat_s[9]; // R3
      status_word[`BBSR_MAINRDY_BIT] = stat_s[8]; // R4
      status_word[`BBSR_BUFRDY_LSB +: 8] = stat_s[7:0]; // R5
   end

   // ==========================================
   // Bus phases and decode
   logic setup;
   logic access;
   logic wr;
   logic is_br;
   logic [1:0] br_idx;
   logic mapped;
   logic [31:0] rd_mux;
   // State record, declared ahead of the decode that reads it
   bbsr_pkg::bbsr_state_s st_q;
   bbsr_pkg::bbsr_state_s st_d;

   assign setup = psel_i & ~penable_i;
   assign access = psel_i & penable_i;
   assign wr = access & pwrite_i;
   assign pready_o = 1'b1; // Zero wait states; data captured in setup

   // Address decoding for reads and error
   always_comb begin
      is_br = 1'b0;
      br_idx = 2'h0;
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      if (hit(paddr_i, `BBSR_UNLOCK_OFF)) begin
         rd_mux = 32'h0000_0000; // Write-only key register
      end else if (hit(paddr_i, `BBSR_REFCTRL_OFF)) begin
         rd_mux[`BBSR_SEL_LSB +: 2] = st_q.adc_ref_input_select;
      end else if (hit(paddr_i, `BBSR_REFSTAT_OFF)) begin
         rd_mux = status_word;
      end else if (paddr_i[11:2] >= `BBSR_BR_BASE_OFF >> 2 &&
                   paddr_i[11:2] < (`BBSR_BR_BASE_OFF >> 2) + `BBSR_BR_COUNT) begin
         is_br = 1'b1;
         br_idx = 2'(paddr_i[11:2] - (`BBSR_BR_BASE_OFF >> 2));
         rd_mux = st_q.retained_general_word[br_idx];
      end else if (hit(paddr_i, `BBSR_BRIF_VER_OFF)) begin
         rd_mux = `BBSR_BRIF_VER; // R8
      end else if (hit(paddr_i, `BBSR_REFIF_VER_OFF)) begin
         rd_mux = `BBSR_REFIF_VER; // R8
      end else if (hit(paddr_i, `BBSR_REGIF_VER_OFF)) begin
         rd_mux = `BBSR_REGIF_VER; // R8
      end else if (hit(paddr_i, `BBSR_BODIF_VER_OFF)) begin
         rd_mux = `BBSR_BODIF_VER; // R8
      end else begin
         mapped = 1'b0;
      end
   end

   // ==========================================
   // State

   // Next state; version and status words have no storage, so writes vanish
   always_comb begin
      st_d = st_q;
      if (setup) begin
         st_d.rdata = pwrite_i ? 32'h0000_0000 : rd_mux;
         st_d.slverr = ~mapped;
      end
      if (access) begin
         // Any completed access spends the unlock, so it must be the very next one
         st_d.unlocked = 1'b0; // R7
      end
      if (wr && mapped) begin
         if (hit(paddr_i, `BBSR_UNLOCK_OFF)) begin
            if (pstrb_i[3] && pwdata_i[`BBSR_KEY_LSB +: 8] == `BBSR_UNLOCK_KEY) begin
               st_d.unlocked = 1'b1;
               st_d.unlock_addr = pwdata_i[`BBSR_UNLOCK_ADDR_W-1:0];
            end
         end else if (hit(paddr_i, `BBSR_REFCTRL_OFF)) begin
            // Reserved codes are dropped so the analog mux never sees them
            if (pstrb_i[0] && (pwdata_i[1:0] == `BBSR_SEL_NONE ||
                               pwdata_i[1:0] == `BBSR_SEL_VREF)) begin
               st_d.adc_ref_input_select = pwdata_i[1:0]; // R1
            end
         end else if (is_br && st_q.unlocked &&
                      st_q.unlock_addr == paddr_i[`BBSR_UNLOCK_ADDR_W-1:0]) begin
            st_d.retained_general_word[br_idx] =
               merge(st_q.retained_general_word[br_idx], pwdata_i, pstrb_i); // R6 R7
         end
      end
   end

   // Registered state; backup reset only, so words survive backup sleep
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q.adc_ref_input_select <= `BBSR_SEL_NONE;
         st_q.unlocked <= 1'b0;
         st_q.unlock_addr <= '0;
         st_q.retained_general_word <= {`BBSR_BR_COUNT{`BBSR_WORD_RESET}}; // R6
         st_q.rdata <= 32'h0000_0000;
         st_q.slverr <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================
   // Outputs
   assign prdata_o = st_q.rdata;
   assign pslverr_o = st_q.slverr & access;
   assign adc_ref_input_select_o = st_q.adc_ref_input_select;
   assign adc_ref_connect_o = (st_q.adc_ref_input_select == `BBSR_SEL_VREF); // R1

   // ==========================================
   // Assertions
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   logic rd_stat;
   logic rd_ver;
   assign rd_stat = setup & ~pwrite_i & hit(paddr_i, `BBSR_REFSTAT_OFF);
   assign rd_ver = setup & ~pwrite_i & hit(paddr_i, `BBSR_BRIF_VER_OFF);

   // Bus events shared by several checks
   logic wr_sel;
   logic wr_unlock;
   logic key_ok;
   logic target_ok;
   assign wr_sel = wr & hit(paddr_i, `BBSR_REFCTRL_OFF);
   assign wr_unlock = wr & hit(paddr_i, `BBSR_UNLOCK_OFF);
   assign key_ok = pstrb_i[3] & (pwdata_i[`BBSR_KEY_LSB +: 8] == `BBSR_UNLOCK_KEY);
   assign target_ok = st_q.unlocked & (st_q.unlock_addr == paddr_i[`BBSR_UNLOCK_ADDR_W-1:0]);

   a_sel_never_reserved: assert property ( // R1
      adc_ref_input_select_o != 2'h1 && adc_ref_input_select_o != 2'h3)
      else $error("reserved ADC select code held");
   a_adc_route_match: assert property ( // R1
      adc_ref_connect_o == (adc_ref_input_select_o == 2'h2))
      else $error("ADC routing disagrees with selector");
   a_vref_field_read: assert property ( // R2
      rd_stat |=> prdata_o[19:18] == $past(vref_used_i, 3))
      else $error("usage field not reported");
   a_lp_ready_read: assert property ( // R3
      rd_stat |=> prdata_o[17] == $past(lowpower_ref_ready_i, 3))
      else $error("low-power ready bit wrong");
   a_main_ready_read: assert property ( // R4
      rd_stat |=> prdata_o[16] == $past(main_ref_ready_i, 3))
      else $error("main ready bit wrong");
   a_buffer_ready_read: assert property ( // R5
      rd_stat |=> prdata_o[7:0] == $past(ref_buffer_ready_i, 3) && prdata_o[15:8] == 8'h00)
      else $error("buffer ready bits wrong");
   a_word_locked_write: assert property ( // R7
      (wr && is_br && !st_q.unlocked) |=> $stable(st_q.retained_general_word))
      else $error("retained word written without unlock");
   a_word_unlock_write: assert property ( // R6
      (wr && is_br && st_q.unlocked && st_q.unlock_addr == paddr_i[9:0] && pstrb_i == 4'hF)
      |=> st_q.retained_general_word[$past(br_idx)] == $past(pwdata_i))
      else $error("unlocked retained write lost");
   a_version_read_only: assert property ( // R8
      rd_ver |=> prdata_o == `BBSR_BRIF_VER ##1 !st_q.slverr [*1])
      else $error("version read wrong");
   a_ro_write_inert: assert property ( // R9
      (wr && (hit(paddr_i, `BBSR_REFSTAT_OFF) || hit(paddr_i, `BBSR_REGIF_VER_OFF)))
      |=> $stable(st_q.retained_general_word) && $stable(st_q.adc_ref_input_select))
      else $error("read-only write had an effect");
   a_ro_write_no_error: assert property ( // R9
      (wr && (hit(paddr_i, `BBSR_REFSTAT_OFF) || hit(paddr_i, `BBSR_BRIF_VER_OFF) ||
              hit(paddr_i, `BBSR_REFIF_VER_OFF) || hit(paddr_i, `BBSR_REGIF_VER_OFF) ||
              hit(paddr_i, `BBSR_BODIF_VER_OFF))) |-> !pslverr_o)
      else $error("read-only write raised an error");

   // Selector writes: legal codes land, reserved codes are dropped
   a_sel_vref_taken: assert property ( // R1
      (wr_sel && pstrb_i[0] && pwdata_i[1:0] == `BBSR_SEL_VREF) |=> adc_ref_connect_o)
      else $error("selector write of the reference code lost");
   a_sel_none_taken: assert property ( // R1
      (wr_sel && pstrb_i[0] && pwdata_i[1:0] == `BBSR_SEL_NONE)
      |=> adc_ref_input_select_o == `BBSR_SEL_NONE && !adc_ref_connect_o)
      else $error("selector write of the idle code lost");
   a_sel_reserved_kept: assert property ( // R1
      (wr_sel && pwdata_i[0]) |=> $stable(adc_ref_input_select_o))
      else $error("reserved selector code changed the field");

   // Status word: nothing above the usage field
   a_status_upper_zero: assert property ( // R2
      rd_stat |=> prdata_o[31:20] == 12'h000)
      else $error("status bits above the usage field set");

   // Unlock: armed by the key, spent by the next access, bound to one word
   a_unlock_armed: assert property ( // R7
      (wr_unlock && key_ok) |=> st_q.unlocked)
      else $error("valid key did not unlock");
   a_unlock_spent: assert property ( // R7
      (access && !(wr_unlock && key_ok)) |=> !st_q.unlocked)
      else $error("unlock outlived the next access");
   a_word_wrong_target: assert property ( // R7
      (wr && is_br && !target_ok) |=> $stable(st_q.retained_general_word))
      else $error("retained word written under another target");
   a_word_byte_merge: assert property ( // R6
      (wr && is_br && target_ok && pstrb_i == 4'h1)
      |=> st_q.retained_general_word[$past(br_idx)] ==
          {$past(st_q.retained_general_word[br_idx][31:8]), $past(pwdata_i[7:0])})
      else $error("byte strobe write merged wrongly");

   // Remaining version words read their constants
   a_ref_version_read: assert property ( // R8
      (setup && !pwrite_i && hit(paddr_i, `BBSR_REFIF_VER_OFF)) |=> prdata_o == `BBSR_REFIF_VER)
      else $error("reference interface version wrong");
   a_reg_version_read: assert property ( // R8
      (setup && !pwrite_i && hit(paddr_i, `BBSR_REGIF_VER_OFF)) |=> prdata_o == `BBSR_REGIF_VER)
      else $error("regulator interface version wrong");
   a_bod_version_read: assert property ( // R8
      (setup && !pwrite_i && hit(paddr_i, `BBSR_BODIF_VER_OFF)) |=> prdata_o == `BBSR_BODIF_VER)
      else $error("brown-out interface version wrong");

   c_unlock_then_write: cover property (
      (wr && hit(paddr_i, `BBSR_UNLOCK_OFF)) ##[2:3] (wr && is_br && st_q.unlocked));
   c_status_read: cover property (rd_stat ##1 prdata_o[16] && prdata_o[17]);
   c_adc_routed: cover property ($rose(adc_ref_connect_o));
   c_unmapped_error: cover property (pslverr_o);
   c_reserved_sel: cover property (wr_sel && pwdata_i[0]);

endmodule

`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the backup reference register bank over APB.
// Assumes bbsr_defines.svh on the include path and bbsr_regs compiled before.
`timescale 1ns/1ps
`default_nettype none
`include "bbsr_defines.svh"

module testbench;
   typedef struct {logic [11:0] a; logic [31:0] v;} bbsr_row_s;
   // ==========
   // Signals
   logic core_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, conn;
   logic [1:0] vref = 2'h0, sel, esel;
   logic main_rdy = 1'b0, lp_rdy = 1'b0;
   logic [7:0] buf_rdy = 8'h00;
   logic [1:0] sv [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
   int n_fail = 0;
   int compares = 0;
   // Plain reads after reset: versions, selector, unlock, retained words
   bbsr_row_s rows [8] = '{'{`BBSR_BRIF_VER_OFF, `BBSR_BRIF_VER}, '{`BBSR_REFIF_VER_OFF, `BBSR_REFIF_VER},
      '{`BBSR_REGIF_VER_OFF, `BBSR_REGIF_VER}, '{`BBSR_BODIF_VER_OFF, `BBSR_BODIF_VER},
      '{`BBSR_REFCTRL_OFF, 32'h0000_0000}, '{`BBSR_UNLOCK_OFF, 32'h0000_0000},
      '{`BBSR_BR_BASE_OFF, 32'h0000_0000}, '{12'h084, 32'h0000_0000}};

   // ==========
   // Clock and design
   always #5 core_clk_i = ~core_clk_i;

   bbsr_regs dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .vref_used_i(vref), .main_ref_ready_i(main_rdy),
      .lowpower_ref_ready_i(lp_rdy), .ref_buffer_ready_i(buf_rdy),
      .adc_ref_input_select_o(sel), .adc_ref_connect_o(conn));

   // ==========
   // Tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %08h expected %08h", $time, got, exp);
      end
   endtask

   // One APB transfer; entered just after an edge, leaves one idle edge after
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge core_clk_i);
      penable <= 1'b1;
      // Wait states are the slave's call; only the watchdog ends a hang
      do begin
         @(posedge core_clk_i);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk_i);
   endtask

   task automatic unl(input logic [11:0] off, input logic [7:0] key);
      apb(1'b1, `BBSR_UNLOCK_OFF, {key, 14'h0000, off[9:0]});
   endtask

   function automatic logic [31:0] stat(input logic [1:0] v, input logic l, m, input logic [7:0] b);
      return {12'h000, v, l, m, 8'h00, b};
   endfunction

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ==========
   // Watchdog, well beyond the fewer than two hundred cycles the tests need
   initial begin
      #200000;
      n_fail++;
      final_report();
   end

   // ==========
   // Main sequence
   initial begin
      repeat (8) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 32'h0000_0000);
         chk(rd, rows[i].v);
      end
      $display("table reads done");
      // Every usage code with changing ready levels; sync needs a few edges
      for (int v = 0; v < 4; v++) begin
         vref <= v[1:0];
         lp_rdy <= v[0];
         main_rdy <= v[1];
         buf_rdy <= 8'h01 << v;
         repeat (4) @(posedge core_clk_i);
         apb(1'b0, `BBSR_REFSTAT_OFF, 32'h0000_0000);
         chk(rd, stat(v[1:0], v[0], v[1], 8'h01 << v));
      end
      // Writes to read-only places change nothing and raise no error
      apb(1'b1, `BBSR_REFSTAT_OFF, 32'hFFFF_FFFF);
      chk({31'h0, err}, 32'h0);
      apb(1'b0, `BBSR_REFSTAT_OFF, 32'h0000_0000);
      chk(rd, stat(2'h3, 1'b1, 1'b1, 8'h08));
      apb(1'b1, `BBSR_REGIF_VER_OFF, 32'hFFFF_FFFF);
      apb(1'b0, `BBSR_REGIF_VER_OFF, 32'h0000_0000);
      chk(rd, `BBSR_REGIF_VER);
      $display("status and version done");
      // Selector: reserved codes leave the field as it was
      esel = 2'h0;
      foreach (sv[i]) begin
         apb(1'b1, `BBSR_REFCTRL_OFF, {30'h0, sv[i]});
         if (sv[i] == 2'h0 || sv[i] == 2'h2) esel = sv[i];
         chk({30'h0, sel}, {30'h0, esel});
         chk({31'h0, conn}, {31'h0, esel == 2'h2});
         apb(1'b0, `BBSR_REFCTRL_OFF, 32'h0000_0000);
         chk(rd, {30'h0, esel});
      end
      $display("selector done");
      // Retained words: unlocked write lands, the other cases are refused
      unl(`BBSR_BR_BASE_OFF, `BBSR_UNLOCK_KEY);
      apb(1'b1, `BBSR_BR_BASE_OFF, 32'hDEAD_BEEF);
      apb(1'b1, 12'h07C, 32'h1234_5678);
      unl(12'h080, 8'h55);
      apb(1'b1, 12'h080, 32'h1111_1111);
      unl(12'h07C, `BBSR_UNLOCK_KEY);
      apb(1'b1, 12'h080, 32'h3333_3333);
      unl(12'h084, `BBSR_UNLOCK_KEY);
      apb(1'b0, `BBSR_BR_BASE_OFF, 32'h0000_0000);
      chk(rd, 32'hDEAD_BEEF);
      apb(1'b1, 12'h084, 32'h2222_2222);
      apb(1'b0, 12'h07C, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h080, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h084, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      // Low byte strobe only: the other three bytes keep their value
      unl(12'h084, `BBSR_UNLOCK_KEY);
      pstrb <= 4'h1;
      apb(1'b1, 12'h084, 32'hAAAA_AA5A);
      pstrb <= 4'hF;
      apb(1'b0, 12'h084, 32'h0000_0000);
      chk(rd, 32'h0000_005A);
      $display("retained words done");
      // Unmapped place answers with an error and zero data
      apb(1'b0, 12'h200, 32'h0000_0000);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0000_0000);
      // Reset in mid-run clears the words and the selector
      unl(`BBSR_REFCTRL_OFF, `BBSR_UNLOCK_KEY);
      apb(1'b1, `BBSR_REFCTRL_OFF, 32'h0000_0002);
      chk({30'h0, sel}, 32'h2);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      chk({30'h0, sel}, 32'h0);
      chk(prdata, 32'h0000_0000);
      chk({30'h0, pready, pslverr}, 32'h2);
      rst_n_i <= 1'b1;
      @(posedge core_clk_i);
      apb(1'b0, `BBSR_BR_BASE_OFF, 32'h0000_0000);
      chk(rd, `BBSR_WORD_RESET);
      chk({30'h0, sel}, 32'h0);
      $display("error and reset done");
      final_report();
   end
endmodule
`default_nettype wire
